// *** logic/one_wire_calib_output_link.sv ***
// Device-side one-wire link: command listening, command mode and normal output.
//
// Behaviour
// RULE_01 - Check both parities; drop frames on edge timeout.
// RULE_02 - Execute each complete valid command pair.
// RULE_03 - Acknowledge successful execution with byte A5.
// RULE_04 - Master treats no acknowledge in 130 ms as failure.
// RULE_05 - Transmit start, eight data, parity per byte.
// RULE_06 - Command mode sends only acknowledge or data.
// RULE_07 - Bridge reading: high byte first, top bits zero.
// RULE_08 - Hold line high 32 us between bytes.
// RULE_09 - Memory dump is one twenty-byte packet.
// RULE_10 - Idle gap follows the update-rate setting.
// RULE_11 - Special measurement every 128/64/16/8 measurements.
// RULE_12 - Bit rate 32 kHz fast, 8 kHz slow.
// RULE_13 - Power down after output at slow rates.
// RULE_14 - Listen 3 ms after reset, then normal mode.
// RULE_15 - Normal mode output follows output configuration.
// RULE_16 - Entry command in window selects command mode.
// RULE_17 - Stay in command mode until normal entry.
// RULE_18 - Only the entry command is accepted first.
// RULE_19 - Master sends each command as 19-bit frame.
// RULE_20 - Sample incoming line at 512 kHz.
// RULE_21 - Master always sends command and data bytes.
// RULE_22 - Bad frames are neither executed nor acknowledged.
`timescale 1ns/1ps
`include "owl_params.svh"
module one_wire_calib_output_link #(
  parameter int unsigned LISTEN_CYC = `LISTEN_CYC,
  parameter int unsigned STOP_CYC = `STOP_CYC,
  parameter int unsigned BIT_FAST_CYC = `BIT_FAST_CYC,
  parameter int unsigned BIT_SLOW_CYC = `BIT_SLOW_CYC,
  parameter int unsigned IDLE0_CYC = `IDLE0_CYC,
  parameter int unsigned IDLE1_CYC = `IDLE1_CYC,
  parameter int unsigned IDLE2_CYC = `IDLE2_CYC,
  parameter int unsigned IDLE3_CYC = `IDLE3_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_line,
  output logic o_line,
  output logic o_line_oe_n,
  input wire logic [1:0] i_update_rate,
  input wire logic [1:0] i_out_mode,
  input wire logic [13:0] i_bridge_data,
  input wire logic [7:0] i_ee_data,
  output logic [4:0] o_ee_addr,
  output owl_pkg::cmd_frame_t o_cmd,
  output logic o_cmd_valid,
  input wire logic i_cmd_done,
  input wire logic i_cmd_ok,
  output owl_pkg::mode_t o_mode,
  output logic o_analog_en,
  output logic o_analog_ratio,
  output logic o_special_meas,
  output logic o_power_down
);
  import owl_pkg::*;

  // ----------------------------------------------------------------
  // Receive sampling and bit decoding.
  // ----------------------------------------------------------------
  logic [8:0] tick_cnt;
  logic rx_prev;
  logic rx_active;
  logic rx_have_ref;
  logic [7:0] per_cnt;
  logic [7:0] low_cnt;
  logic [7:0] ref_half;
  logic [4:0] rx_nbits;
  logic [17:0] rx_shift;
  logic frame_ok;
  mode_t mode;
  tx_state_t tx_state;
  logic exec_wait;

  wire tick = (tick_cnt == 9'(`RX_TICK_CYC - 1));
  wire rx_enable = ((mode == M_LISTEN) || (mode == M_CMD)) && (tx_state == T_IDLE) && !exec_wait;
  wire fall = tick && rx_prev && !i_line;
  wire rise = tick && !rx_prev && i_line;
  wire rx_timeout = rx_active && (per_cnt >= `RX_TIMEOUT_TICKS);
  wire bit_val = (low_cnt < ref_half);
  wire [17:0] next_rx_shift = {rx_shift[16:0], bit_val};
  wire last_bit = rise && rx_have_ref && (rx_nbits == `RX_FRAME_BITS - 5'h1);
  wire par_ok = !(^next_rx_shift[17:9]) && !(^next_rx_shift[8:0]);
  wire cmd_frame_t rx_frame = '{cmd: rx_shift[17:10], data: rx_shift[8:1]};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 9'h000;
      rx_prev <= 1'b1;
    end else if (i_ce) begin
      tick_cnt <= tick ? 9'h000 : tick_cnt + 9'h001; // see RULE_20
      if (tick) begin
        rx_prev <= i_line;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_active <= 1'b0;
      rx_have_ref <= 1'b0;
      per_cnt <= 8'h00;
      low_cnt <= 8'h00;
      ref_half <= 8'h00;
      rx_nbits <= 5'h00;
      rx_shift <= 18'h00000;
      frame_ok <= 1'b0;
    end else if (i_ce) begin
      frame_ok <= 1'b0;
      if (!rx_enable || rx_timeout || last_bit) begin
        rx_active <= 1'b0; // see RULE_01
        rx_have_ref <= 1'b0;
        rx_nbits <= 5'h00;
        frame_ok <= rx_enable && last_bit && par_ok; // see RULE_01, RULE_22
        if (last_bit) begin
          rx_shift <= next_rx_shift;
        end
      end else if (fall) begin
        rx_active <= 1'b1;
        per_cnt <= 8'h00;
        low_cnt <= 8'h00;
        if (rx_active && !rx_have_ref) begin
          rx_have_ref <= 1'b1;
          ref_half <= {1'b0, per_cnt[7:1]};
        end
      end else if (tick && rx_active) begin
        per_cnt <= per_cnt + 8'h01;
        if (!i_line) begin
          low_cnt <= low_cnt + 8'h01;
        end
        if (rise && rx_have_ref) begin
          rx_shift <= next_rx_shift;
          rx_nbits <= rx_nbits + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode control and command execution.
  // ----------------------------------------------------------------
  logic [19:0] listen_cnt;
  logic go_normal;
  logic pkt_start;
  pkt_kind_t pkt_kind;
  logic tx_done;

  wire is_cm_entry = (rx_frame.cmd == `CMD_CM_ENTRY) && (rx_frame.data == `DATA_CM_ENTRY);
  wire is_nom_entry = (rx_frame.cmd == `CMD_NOM_ENTRY) && (rx_frame.data == `DATA_NOM_ENTRY);
  wire is_read_ee = (rx_frame.cmd == `CMD_READ_EE);
  wire listen_over = (listen_cnt == 20'(LISTEN_CYC - 1));
  wire ext_ack = exec_wait && i_cmd_done && i_cmd_ok;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= M_LISTEN;
      listen_cnt <= 20'h00000;
      go_normal <= 1'b0;
      exec_wait <= 1'b0;
      o_cmd <= '0;
      o_cmd_valid <= 1'b0;
    end else if (i_ce) begin
      o_cmd_valid <= 1'b0;
      case (mode)
        M_LISTEN: begin
          listen_cnt <= listen_cnt + 20'h00001;
          if (frame_ok && is_cm_entry) begin
            mode <= M_CMD; // see RULE_16, RULE_18
          end else if (listen_over) begin
            mode <= M_NORMAL; // see RULE_14
          end
        end
        M_CMD: begin
          if (frame_ok && is_nom_entry) begin
            go_normal <= 1'b1; // see RULE_17
          end else if (frame_ok && !is_cm_entry && !is_read_ee) begin
            o_cmd <= rx_frame; // see RULE_02
            o_cmd_valid <= 1'b1;
            exec_wait <= 1'b1;
          end
          if (exec_wait && i_cmd_done) begin
            exec_wait <= 1'b0;
          end
          if (go_normal && tx_done) begin
            go_normal <= 1'b0;
            mode <= M_NORMAL;
          end
        end
        default: begin
          mode <= M_NORMAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Normal operation scheduling.
  // ----------------------------------------------------------------
  logic [24:0] idle_cnt;
  logic [7:0] meas_cnt;
  logic [13:0] bridge;

  wire slow_rate = i_update_rate[1];
  wire digital_out = (i_out_mode == `OUT_DIGITAL);
  wire [24:0] idle_lim = (i_update_rate == 2'h0) ? 25'(IDLE0_CYC) :
                         (i_update_rate == 2'h1) ? 25'(IDLE1_CYC) :
                         (i_update_rate == 2'h2) ? 25'(IDLE2_CYC) : 25'(IDLE3_CYC); // see RULE_10
  wire [7:0] special_n = (i_update_rate == 2'h0) ? `SPECIAL0_N :
                         (i_update_rate == 2'h1) ? `SPECIAL1_N :
                         (i_update_rate == 2'h2) ? `SPECIAL2_N : `SPECIAL3_N;
  wire meas_due = (mode == M_NORMAL) && (tx_state == T_IDLE) && (idle_cnt >= idle_lim - 25'h0000001);
  wire ack_due = (mode == M_CMD) && (tx_state == T_IDLE) &&
                 ((frame_ok && (is_cm_entry || is_nom_entry)) || ext_ack); // see RULE_03, RULE_06
  wire ee_due = (mode == M_CMD) && (tx_state == T_IDLE) && frame_ok && is_read_ee;
  wire cm_entry_ack = (mode == M_LISTEN) && frame_ok && is_cm_entry;

  assign pkt_start = ack_due || ee_due || cm_entry_ack || (meas_due && digital_out);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt <= 25'h0000000;
      meas_cnt <= 8'h00;
      o_special_meas <= 1'b0;
      o_power_down <= 1'b0;
      bridge <= 14'h0000;
    end else if (i_ce) begin
      o_special_meas <= 1'b0;
      if (tx_state == T_IDLE) begin
        bridge <= i_bridge_data;
      end
      if (meas_due) begin
        idle_cnt <= 25'h0000000;
        o_power_down <= 1'b0;
        meas_cnt <= (meas_cnt == special_n - 8'h01) ? 8'h00 : meas_cnt + 8'h01;
        o_special_meas <= (meas_cnt == special_n - 8'h01); // see RULE_11
      end else if ((mode == M_NORMAL) && (tx_state == T_IDLE)) begin
        idle_cnt <= idle_cnt + 25'h0000001;
      end
      if ((mode == M_NORMAL) && tx_done && slow_rate) begin
        o_power_down <= 1'b1; // see RULE_13
      end
    end
  end

  assign o_mode = mode;
  assign o_analog_en = (mode == M_NORMAL) && !digital_out; // see RULE_15
  assign o_analog_ratio = (i_out_mode == `OUT_ANALOG_RATIO);

  // ----------------------------------------------------------------
  // Byte transmitter.
  // ----------------------------------------------------------------
  logic [24:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [9:0] tx_shift;
  logic [4:0] byte_idx;
  logic [4:0] pkt_len;
  logic [7:0] cur_byte;

  wire [24:0] bit_len = slow_rate ? 25'(BIT_SLOW_CYC) : 25'(BIT_FAST_CYC); // see RULE_12
  wire [24:0] low_one = {2'b00, bit_len[24:2]};
  wire [24:0] low_zero = bit_len - low_one;
  wire [24:0] low_len = tx_shift[9] ? low_one : low_zero;
  wire bit_end = (tx_cnt == bit_len - 25'h0000001);
  wire stop_end = (tx_cnt == 25'(STOP_CYC - 1));
  wire pkt_kind_t next_kind = ee_due ? K_EEPROM : (meas_due && !ack_due && !cm_entry_ack) ? K_BRIDGE : K_ACK;
  wire pkt_kind_t kind_sel = (tx_state == T_IDLE) ? next_kind : pkt_kind;
  wire [7:0] src_byte = (kind_sel == K_ACK) ? `ACK_BYTE :
                        (kind_sel == K_EEPROM) ? i_ee_data :
                        (byte_idx == 5'h00) ? {2'b00, bridge[13:8]} : bridge[7:0]; // see RULE_07
  wire [9:0] frame_bits = {1'b0, src_byte, ^src_byte}; // see RULE_05

  assign cur_byte = src_byte;
  assign o_ee_addr = byte_idx;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state <= T_IDLE;
      tx_cnt <= 25'h0000000;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3FF;
      byte_idx <= 5'h00;
      pkt_len <= 5'h00;
      pkt_kind <= K_ACK;
      tx_done <= 1'b0;
      o_line <= 1'b1;
      o_line_oe_n <= 1'b1;
    end else if (i_ce) begin
      tx_done <= 1'b0;
      case (tx_state)
        T_IDLE: begin
          o_line <= 1'b1;
          o_line_oe_n <= 1'b1;
          byte_idx <= 5'h00;
          if (pkt_start) begin
            tx_state <= T_BITS;
            pkt_kind <= next_kind;
            pkt_len <= ee_due ? `EE_BYTES : (next_kind == K_BRIDGE) ? `BRIDGE_BYTES : 5'h01; // see RULE_09
            tx_shift <= frame_bits;
            tx_cnt <= 25'h0000000;
            tx_bit <= 4'h0;
          end
        end
        T_BITS: begin
          o_line_oe_n <= 1'b0;
          o_line <= (tx_cnt >= low_len);
          tx_cnt <= bit_end ? 25'h0000000 : tx_cnt + 25'h0000001;
          if (bit_end) begin
            tx_shift <= {tx_shift[8:0], 1'b1};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == `TX_BITS - 4'h1) begin
              tx_state <= T_STOP;
              byte_idx <= byte_idx + 5'h01;
            end
          end
        end
        default: begin
          o_line_oe_n <= 1'b0;
          o_line <= 1'b1; // see RULE_08
          tx_cnt <= stop_end ? 25'h0000000 : tx_cnt + 25'h0000001;
          if (stop_end) begin
            tx_bit <= 4'h0;
            if (byte_idx == pkt_len) begin
              tx_state <= T_IDLE;
              tx_done <= 1'b1;
            end else begin
              tx_state <= T_BITS;
              tx_shift <= {1'b0, cur_byte, ^cur_byte};
            end
          end
        end
      endcase
    end
  end
endmodule : one_wire_calib_output_link

// *** pkg/owl_params.svh ***
// Constants for the one-wire calibration and output link.
`ifndef OWL_PARAMS_SVH
`define OWL_PARAMS_SVH
`define CLK_HZ 250000000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define RX_SAMPLE_HZ 512000
`define RX_TICK_CYC (`CLK_HZ / `RX_SAMPLE_HZ)
`define RX_TIMEOUT_TICKS 8'hC8
`define RX_FRAME_BITS 5'h12
`define ACK_BYTE 8'hA5
`define CMD_CM_ENTRY 8'h50
`define DATA_CM_ENTRY 8'h90
`define CMD_NOM_ENTRY 8'h40
`define DATA_NOM_ENTRY 8'h00
`define CMD_READ_EE 8'h00
`define EE_BYTES 5'h14
`define BRIDGE_BYTES 5'h02
`define TX_BITS 4'hA
`define LISTEN_US 3000
`define LISTEN_CYC (`LISTEN_US * `CYC_PER_US)
`define STOP_US 32
`define STOP_CYC (`STOP_US * `CYC_PER_US)
`define BAUD_FAST_HZ 32000
`define BAUD_SLOW_HZ 8000
`define BIT_FAST_CYC (`CLK_HZ / `BAUD_FAST_HZ)
`define BIT_SLOW_CYC (`CLK_HZ / `BAUD_SLOW_HZ)
`define IDLE0_US 1000
`define IDLE1_US 4850
`define IDLE2_US 22500
`define IDLE3_US 118000
`define IDLE0_CYC (`IDLE0_US * `CYC_PER_US)
`define IDLE1_CYC (`IDLE1_US * `CYC_PER_US)
`define IDLE2_CYC (`IDLE2_US * `CYC_PER_US)
`define IDLE3_CYC (`IDLE3_US * `CYC_PER_US)
`define SPECIAL0_N 8'h80
`define SPECIAL1_N 8'h40
`define SPECIAL2_N 8'h10
`define SPECIAL3_N 8'h08
`define OUT_ANALOG_ABS 2'h0
`define OUT_ANALOG_RATIO 2'h1
`define OUT_DIGITAL 2'h2
`endif

// *** pkg/owl_pkg.sv ***
// Types shared by the one-wire calibration and output link.
package owl_pkg;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } cmd_frame_t;
  typedef enum logic [1:0] {M_LISTEN, M_CMD, M_NORMAL} mode_t;
  typedef enum logic [1:0] {T_IDLE, T_BITS, T_STOP} tx_state_t;
  typedef enum logic [1:0] {K_ACK, K_BRIDGE, K_EEPROM} pkt_kind_t;
endpackage : owl_pkg

// *** verif/one_wire_calib_output_link_properties.sv ***
// Port checks for the one-wire calibration and output link.
`timescale 1ns/1ps
module one_wire_calib_output_link_properties #(
  parameter int unsigned LISTEN_CYC = 2000,
  parameter int unsigned BIT_FAST_CYC = 200,
  parameter int unsigned BIT_SLOW_CYC = 400
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [1:0] i_update_rate,
  input wire logic [1:0] i_out_mode,
  input wire logic o_line,
  input wire logic o_line_oe_n,
  input wire owl_pkg::cmd_frame_t o_cmd,
  input wire logic o_cmd_valid,
  input wire owl_pkg::mode_t o_mode,
  input wire logic o_analog_en,
  input wire logic o_analog_ratio
);
  import owl_pkg::*;
  logic [31:0] listen_cnt;
  logic [31:0] low_cnt;
  wire [31:0] bit_cyc = i_update_rate[1] ? BIT_SLOW_CYC : BIT_FAST_CYC;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      listen_cnt <= '0;
      low_cnt <= '0;
    end else begin
      listen_cnt <= i_ce ? listen_cnt + 1 : listen_cnt;
      low_cnt <= o_line ? '0 : low_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  cmd_in_mode_a: assert property (o_cmd_valid |-> o_mode == M_CMD)
    else $error("Command strobe outside command mode.");
  cmd_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("Command strobe longer than one cycle.");
  cmd_hold_a: assert property ($changed(o_cmd) |-> o_cmd_valid)
    else $error("Command changed without strobe.");
  analog_en_a: assert property (o_analog_en == (o_mode == M_NORMAL && i_out_mode != 2'h2))
    else $error("Analog enable wrong.");
  analog_ratio_a: assert property (o_analog_ratio == (i_out_mode == 2'h1))
    else $error("Ratiometric select wrong.");
  listen_len_a: assert property (o_mode == M_LISTEN |-> listen_cnt <= LISTEN_CYC + 2)
    else $error("Listen window too long.");
  listen_exit_a: assert property ($past(o_mode) == M_LISTEN && o_mode == M_NORMAL |-> listen_cnt >= LISTEN_CYC - 2)
    else $error("Listen window left early.");
  cmd_sticky_a: assert property (o_mode == M_CMD |=> o_mode != M_LISTEN)
    else $error("Command mode left for listen.");
  bit_len_a: assert property ($rose(o_line) && !o_line_oe_n |-> low_cnt == bit_cyc / 4 || low_cnt == bit_cyc - bit_cyc / 4)
    else $error("Bit low time wrong.");
  release_high_a: assert property (o_line_oe_n |-> o_line)
    else $error("Released line not high.");
  cover property (o_cmd_valid);
  cover property ($rose(o_mode == M_CMD));
  cover property ($rose(o_mode == M_NORMAL));
endmodule : one_wire_calib_output_link_properties

// *** verif/owl_master_model.sv ***
// Calibration master model: sends write frames and decodes device bytes.
`timescale 1ns/1ps
module owl_master_model #(
  parameter int unsigned MBIT_CYC = 5208,
  parameter int unsigned DEV_HALF_CYC = 125
) (
  input wire logic i_clk,
  input wire logic i_wire,
  output logic o_pull_low
);
  logic [7:0] rx_q[$];
  logic [9:0] shreg;
  int rx_bits;
  int rx_err;
  int low_len;
  int high_len;
  initial o_pull_low = 1'b0;
  task automatic send_bit(input logic b);
    int lo;
    lo = b ? MBIT_CYC / 4 : MBIT_CYC - MBIT_CYC / 4;
    @(posedge i_clk) #1 o_pull_low = 1'b1;
    repeat (lo) @(posedge i_clk);
    #1 o_pull_low = 1'b0;
    repeat (MBIT_CYC - lo - 1) @(posedge i_clk);
  endtask : send_bit
  task automatic send_frame(input logic [7:0] cmd, input logic [7:0] data, input logic bad);
    logic [17:0] bits;
    bits = {cmd, ^cmd ^ bad, data, ^data};
    send_bit(1'b1);
    for (int i = 17; i >= 0; i--) begin
      send_bit(bits[i]);
    end
  endtask : send_frame
  always @(posedge i_clk) begin
    if (!i_wire && !o_pull_low) begin
      low_len++;
      high_len = 0;
    end else begin
      if (low_len != 0) begin
        shreg = {shreg[8:0], low_len < DEV_HALF_CYC};
        rx_bits++;
        if (rx_bits == 10) begin
          if (shreg[9] !== 1'b0 || ^shreg[8:0] !== 1'b0) rx_err++;
          rx_q.push_back(shreg[8:1]);
          rx_bits = 0;
        end
      end
      low_len = 0;
      high_len++;
      if (high_len > 900) rx_bits = 0;
    end
  end
endmodule : owl_master_model

// *** verif/one_wire_calib_output_link_tb.sv ***
// Self-checking bench for the one-wire calibration and output link.
`timescale 1ns/1ps
module one_wire_calib_output_link_tb;
  import owl_pkg::*;
  localparam int unsigned LISTEN = 120000;
  localparam int unsigned STOP = 40, BIT_F = 200, BIT_S = 400, IDLE3 = 4000;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [1:0] i_update_rate = 2'h0;
  logic [1:0] i_out_mode = 2'h2;
  logic [13:0] i_bridge_data = 14'h2ABC;
  logic i_cmd_done = 1'b0;
  logic i_cmd_ok = 1'b0;
  logic o_line, o_line_oe_n, o_cmd_valid, o_analog_en, o_analog_ratio, o_special_meas, o_power_down, pull_low;
  logic [4:0] o_ee_addr;
  cmd_frame_t o_cmd;
  mode_t o_mode;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_strobe = 0;
  wire [7:0] ee_byte = {3'h5, o_ee_addr};
  wire line_lvl = !pull_low && (o_line_oe_n || o_line);
  one_wire_calib_output_link #(.LISTEN_CYC(LISTEN), .STOP_CYC(STOP), .BIT_FAST_CYC(BIT_F), .BIT_SLOW_CYC(BIT_S),
    .IDLE0_CYC(1000), .IDLE1_CYC(2000), .IDLE2_CYC(3000), .IDLE3_CYC(IDLE3)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_line(line_lvl), .o_line(o_line), .o_line_oe_n(o_line_oe_n),
    .i_update_rate(i_update_rate), .i_out_mode(i_out_mode), .i_bridge_data(i_bridge_data), .i_ee_data(ee_byte),
    .o_ee_addr(o_ee_addr), .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .i_cmd_done(i_cmd_done), .i_cmd_ok(i_cmd_ok),
    .o_mode(o_mode), .o_analog_en(o_analog_en), .o_analog_ratio(o_analog_ratio), .o_special_meas(o_special_meas),
    .o_power_down(o_power_down));
  owl_master_model u_master (.i_clk(i_clk), .i_wire(line_lvl), .o_pull_low(pull_low));
  always #2 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (o_cmd_valid === 1'b1) begin
      n_strobe++;
    end
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 900000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic send(input logic [7:0] c, input logic [7:0] d, input logic bad);
    repeat (1000) @(posedge i_clk);
    u_master.rx_q.delete();
    u_master.send_frame(c, d, bad);
  endtask : send
  task automatic wait_bytes(input int n, input int lim);
    for (int k = 0; k < lim && u_master.rx_q.size() < n; k++) begin
      @(posedge i_clk);
    end
    check("byte count", 16'(n), 16'(u_master.rx_q.size()));
  endtask : wait_bytes
  task automatic wait_special(input bit freeze, output int k);
    k = 0;
    do begin
      @(posedge i_clk) #1;
      k++;
      if (freeze) begin
        i_ce = (k < 10) || (k >= 110);
      end
    end while (o_special_meas !== 1'b1 && k < 40000);
  endtask : wait_special
  task automatic test_listen_normal();
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    send(8'h40, 8'h00, 1'b0);
    repeat (2000) @(posedge i_clk);
    check("mode in window", 16'(M_LISTEN), 16'(o_mode));
    check("bytes in window", 16'h0000, 16'(u_master.rx_q.size()));
    wait_bytes(2, LISTEN);
    check("mode after window", 16'(M_NORMAL), 16'(o_mode));
    check("high byte", {10'h000, i_bridge_data[13:8]}, 16'(u_master.rx_q[0]));
    check("low byte", {8'h00, i_bridge_data[7:0]}, 16'(u_master.rx_q[1]));
    $display("listen_normal done");
  endtask : test_listen_normal
  task automatic test_enter_cmd();
    #1 i_rst = 1'b1;
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    send(8'h50, 8'h90, 1'b0);
    wait_bytes(1, 20000);
    check("entry ack", 16'h00A5, 16'(u_master.rx_q[0]));
    check("mode", 16'(M_CMD), 16'(o_mode));
    $display("enter_cmd done");
  endtask : test_enter_cmd
  task automatic test_bad_parity();
    send(8'h30, 8'h31, 1'b1);
    repeat (4000) @(posedge i_clk);
    check("strobe on bad frame", 16'h0000, 16'(n_strobe));
    check("bytes after bad frame", 16'h0000, 16'(u_master.rx_q.size()));
    $display("bad_parity done");
  endtask : test_bad_parity
  task automatic test_exec();
    send(8'h30, 8'h31, 1'b0);
    repeat (10) @(posedge i_clk);
    check("command strobes", 16'h0001, 16'(n_strobe));
    check("forwarded command", 16'h3031, o_cmd);
    check("bytes before done", 16'h0000, 16'(u_master.rx_q.size()));
    #1 i_cmd_done = 1'b1;
    i_cmd_ok = 1'b1;
    @(posedge i_clk) #1 i_cmd_done = 1'b0;
    wait_bytes(1, 20000);
    check("command ack", 16'h00A5, 16'(u_master.rx_q[0]));
    $display("exec done");
  endtask : test_exec
  task automatic test_dump();
    send(8'h00, 8'h00, 1'b0);
    wait_bytes(20, 60000);
    repeat (3000) @(posedge i_clk);
    check("dump length", 16'd20, 16'(u_master.rx_q.size()));
    for (int i = 0; i < 20; i++) begin
      check("dump byte", {8'h00, 3'h5, 5'(i)}, 16'(u_master.rx_q[i]));
    end
    $display("dump done");
  endtask : test_dump
  task automatic test_normal_entry();
    #1 i_update_rate = 2'h2;
    send(8'h40, 8'h00, 1'b0);
    wait_bytes(1, 20000);
    check("normal entry ack", 16'h00A5, 16'(u_master.rx_q[0]));
    repeat (500) @(posedge i_clk);
    check("mode after entry", 16'(M_NORMAL), 16'(o_mode));
    wait_bytes(3, 40000);
    repeat (500) @(posedge i_clk);
    check("slow high byte", {10'h000, i_bridge_data[13:8]}, 16'(u_master.rx_q[1]));
    check("slow low byte", {8'h00, i_bridge_data[7:0]}, 16'(u_master.rx_q[2]));
    check("power down", 16'h0001, 16'(o_power_down));
    $display("normal_entry done");
  endtask : test_normal_entry
  task automatic test_special();
    int k;
    #1 i_out_mode = 2'h0;
    i_update_rate = 2'h3;
    wait_special(1'b0, k);
    wait_special(1'b1, k);
    check("special period", 16'(8 * IDLE3 + 100), 16'(k));
    check("analog enable", 16'h0001, 16'(o_analog_en));
    $display("special done");
  endtask : test_special
  initial begin
    test_listen_normal();
    test_enter_cmd();
    test_bad_parity();
    test_exec();
    test_dump();
    test_normal_entry();
    test_special();
    check("device byte errors", 16'h0000, 16'(u_master.rx_err));
    finish_test();
  end
endmodule : one_wire_calib_output_link_tb
bind one_wire_calib_output_link one_wire_calib_output_link_properties #(.LISTEN_CYC(LISTEN_CYC),
  .BIT_FAST_CYC(BIT_FAST_CYC), .BIT_SLOW_CYC(BIT_SLOW_CYC)) u_props (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_update_rate(i_update_rate), .i_out_mode(i_out_mode), .o_line(o_line), .o_line_oe_n(o_line_oe_n),
  .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_mode(o_mode), .o_analog_en(o_analog_en),
  .o_analog_ratio(o_analog_ratio));
